// ### rtl/paired_timer_pkg.sv
package paired_timer_pkg;

  localparam int          NUM_TMR   = 4;
  localparam int          NUM_PAIR  = 2;
  localparam int          ADDR_W    = 12;
  localparam int          IDX_W     = 10;
  localparam int          DATA_W    = 16;
  localparam int          PRE_W     = 8;

  // register indices; byte address is four times the index
  localparam logic [9:0]  CNT_IDX [4] = '{10'h106, 10'h10a, 10'h114, 10'h118};
  localparam logic [9:0]  PER_IDX [4] = '{10'h10c, 10'h10e, 10'h11a, 10'h11c};
  localparam logic [9:0]  CON_IDX [4] = '{10'h110, 10'h112, 10'h11e, 10'h120};
  localparam logic [9:0]  HOLD_IDX [2] = '{10'h108, 10'h116};
  localparam logic [9:0]  FLAG_IDX = 10'h122;
  localparam logic [9:0]  ENA_IDX  = 10'h124;

  // control field positions
  localparam int          BIT_ON    = 15;
  localparam int          BIT_IDLE  = 13;
  localparam int          BIT_GATE  = 6;
  localparam int          BIT_PRE_H = 5;
  localparam int          BIT_PRE_L = 4;
  localparam int          BIT_WIDE  = 3;
  localparam int          BIT_CSRC  = 1;

  localparam logic [15:0] PER_RST   = 16'hffff;
  localparam logic [15:0] CON_RST   = 16'h0000;
  localparam logic [15:0] CNT_WRAP  = 16'hffff;
  localparam logic [15:0] CON_MASK [4] = '{16'ha07a, 16'ha072, 16'ha07a, 16'ha072};

  // event flag / enable bit per timer
  localparam int          FLAG_POS [4] = '{6, 7, 8, 9};

  // last prescale count for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0]  PRE_LAST [4] = '{8'h00, 8'h07, 8'h3f, 8'hff};

endpackage : paired_timer_pkg

// ### rtl/paired_timer_32bit.sv
// Chosen here: the APB register port.
module paired_timer_32bit
  import paired_timer_pkg::*;
(
  input  wire logic                              i_core_clk,
  input  wire logic                              i_reset,
  input  wire logic                              i_psel,
  input  wire logic                              i_penable,
  input  wire logic                              i_pwrite,
  input  wire logic [paired_timer_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]                       i_pwdata,
  output logic      [31:0]                       o_prdata,
  output logic                                   o_pready,
  output logic                                   o_pslverr,
  input  wire logic                              i_sleep,
  input  wire logic                              i_idle,
  input  wire logic [paired_timer_pkg::NUM_TMR-1:0] i_timer_pin,
  output logic                                   o_pair_a_irq,
  output logic                                   o_pair_b_irq,
  output logic                                   o_adc_trigger,
  output logic      [15:0]                       o_timebase_low,
  output logic      [15:0]                       o_timebase_high
);
  import paired_timer_pkg::*;

  // counts and holds carry no reset: their value is undefined until written
  logic [15:0]        cnt_q   [NUM_TMR];
  logic [15:0]        cnt_d   [NUM_TMR];
  logic [15:0]        per_q   [NUM_TMR];
  logic [15:0]        con_q   [NUM_TMR];
  logic [PRE_W-1:0]   pre_q   [NUM_TMR];
  logic [15:0]        hold_q  [NUM_PAIR];
  logic [NUM_TMR-1:0] flag_q;
  logic [NUM_TMR-1:0] ena_q;
  logic [NUM_TMR-1:0] sync1_q;
  logic [NUM_TMR-1:0] sync2_q;
  logic [NUM_TMR-1:0] sync3_q;

  logic [NUM_TMR-1:0] run;
  logic [NUM_TMR-1:0] src;
  logic [NUM_TMR-1:0] tick;
  logic [NUM_TMR-1:0] gate_fall;
  logic [NUM_TMR-1:0] match;
  logic [NUM_TMR-1:0] ev;
  logic [NUM_TMR-1:0] wr_cnt;
  logic [NUM_TMR-1:0] wr_per;
  logic [NUM_TMR-1:0] wr_con;
  logic [NUM_PAIR-1:0] wr_hold;
  logic [NUM_PAIR-1:0] rd_low;
  logic [NUM_PAIR-1:0] wide;
  logic               wr_flag;
  logic               wr_ena;
  logic               wr_acc;
  logic               rd_set;
  logic               aligned;
  logic               hit;
  logic [IDX_W-1:0]   idx;
  logic [15:0]        rd_d;
  logic [15:0]        wdat;

  // pin synchroniser; the first stage feeds only the second
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= i_timer_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // bus decode
  always_comb begin
    wdat    = i_pwdata[15:0];
    idx     = i_paddr[ADDR_W-1:2];
    aligned = (i_paddr[1:0] == 2'b00);
    wr_acc  = i_psel & i_penable & i_pwrite & aligned;
    rd_set  = i_psel & ~i_penable & ~i_pwrite & aligned;
    wr_flag = wr_acc & (idx == FLAG_IDX);
    wr_ena  = wr_acc & (idx == ENA_IDX);
    for (int t = 0; t < NUM_TMR; t++) begin
      wr_cnt[t] = wr_acc & (idx == CNT_IDX[t]);
      wr_per[t] = wr_acc & (idx == PER_IDX[t]);
      wr_con[t] = wr_acc & (idx == CON_IDX[t]);
    end
    for (int p = 0; p < NUM_PAIR; p++) begin
      wr_hold[p] = wr_acc & (idx == HOLD_IDX[p]);
      rd_low[p]  = rd_set & (idx == CNT_IDX[2*p]);
    end
  end

  // read mux
  always_comb begin
    rd_d = '0;
    hit  = 1'b0;
    if (idx == FLAG_IDX) begin
      hit = 1'b1;
      for (int t = 0; t < NUM_TMR; t++) begin
        rd_d[FLAG_POS[t]] = flag_q[t];
      end
    end else if (idx == ENA_IDX) begin
      hit = 1'b1;
      for (int t = 0; t < NUM_TMR; t++) begin
        rd_d[FLAG_POS[t]] = ena_q[t];
      end
    end
    for (int t = 0; t < NUM_TMR; t++) begin
      if (idx == CNT_IDX[t]) begin
        hit  = 1'b1;
        rd_d = cnt_q[t];
      end else if (idx == PER_IDX[t]) begin
        hit  = 1'b1;
        rd_d = per_q[t];
      end else if (idx == CON_IDX[t]) begin
        hit  = 1'b1;
        rd_d = con_q[t];
      end
    end
    for (int p = 0; p < NUM_PAIR; p++) begin
      if (idx == HOLD_IDX[p]) begin
        hit  = 1'b1;
        rd_d = hold_q[p];
      end
    end
  end

  // zero-wait slave: read data is captured in the setup cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= 1'b1;
      if (i_psel && !i_penable) begin
        o_prdata  <= (i_pwrite || !hit) ? 32'h0000_0000 : {16'h0000, rd_d};
        o_pslverr <= ~(aligned & hit);
      end
    end
  end

  // period and control registers
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      for (int t = 0; t < NUM_TMR; t++) begin
        per_q[t] <= PER_RST;
        con_q[t] <= CON_RST;
      end
    end else begin
      for (int t = 0; t < NUM_TMR; t++) begin
        if (wr_per[t]) begin
          per_q[t] <= wdat;
        end
        if (wr_con[t]) begin
          con_q[t] <= wdat & CON_MASK[t];
        end
      end
    end
  end

  // count qualification per timer
  always_comb begin
    for (int p = 0; p < NUM_PAIR; p++) begin
      wide[p] = con_q[2*p][BIT_WIDE];
    end
    for (int t = 0; t < NUM_TMR; t++) begin
      // upper timer's own setup is dead while its pair is wide
      run[t] = con_q[t][BIT_ON] & ~i_sleep & ~(i_idle & con_q[t][BIT_IDLE]);
      if (con_q[t][BIT_CSRC]) begin
        src[t] = sync2_q[t] & ~sync3_q[t];
      end else if (con_q[t][BIT_GATE]) begin
        src[t] = sync2_q[t];
      end else begin
        src[t] = 1'b1;
      end
      tick[t] = run[t] & src[t] &
                (pre_q[t] == PRE_LAST[con_q[t][BIT_PRE_H:BIT_PRE_L]]);
      gate_fall[t] = run[t] & ~con_q[t][BIT_CSRC] & con_q[t][BIT_GATE] &
                     ~sync2_q[t] & sync3_q[t];
    end
  end

  // prescaler; cleared on count write or disable
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      for (int t = 0; t < NUM_TMR; t++) begin
        pre_q[t] <= '0;
      end
    end else begin
      for (int t = 0; t < NUM_TMR; t++) begin
        if (!con_q[t][BIT_ON] || wr_cnt[t]) begin
          pre_q[t] <= '0;
        end else if (run[t] && src[t]) begin
          pre_q[t] <= tick[t] ? '0 : pre_q[t] + 8'h01;
        end
      end
    end
  end

  // counter next state and events
  always_comb begin
    for (int p = 0; p < NUM_PAIR; p++) begin
      cnt_d[2*p]   = cnt_q[2*p];
      cnt_d[2*p+1] = cnt_q[2*p+1];
      match[2*p]   = 1'b0;
      match[2*p+1] = 1'b0;
      ev[2*p]      = 1'b0;
      ev[2*p+1]    = 1'b0;
      if (wide[p]) begin
        // lower timer's clock, gate and prescaler drive the pair
        if (tick[2*p]) begin
          if ({cnt_q[2*p+1], cnt_q[2*p]} == {per_q[2*p+1], per_q[2*p]}) begin
            cnt_d[2*p]     = '0;
            cnt_d[2*p+1]   = '0;
            match[2*p+1]   = 1'b1;
          end else begin
            cnt_d[2*p] = cnt_q[2*p] + 16'h0001;
            if (cnt_q[2*p] == CNT_WRAP) begin
              cnt_d[2*p+1] = cnt_q[2*p+1] + 16'h0001;
            end
          end
        end
        ev[2*p+1] = match[2*p+1] | gate_fall[2*p];
      end else begin
        for (int h = 0; h < 2; h++) begin
          if (tick[2*p+h]) begin
            if (cnt_q[2*p+h] == per_q[2*p+h]) begin
              cnt_d[2*p+h] = '0;
              match[2*p+h] = 1'b1;
            end else begin
              cnt_d[2*p+h] = cnt_q[2*p+h] + 16'h0001;
            end
          end
          ev[2*p+h] = match[2*p+h] | gate_fall[2*p+h];
        end
      end
      // software writes override counting
      if (wr_cnt[2*p]) begin
        cnt_d[2*p] = wdat;
        if (wide[p]) begin
          cnt_d[2*p+1] = hold_q[p];
        end
      end
      if (wr_cnt[2*p+1]) begin
        cnt_d[2*p+1] = wdat;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    for (int t = 0; t < NUM_TMR; t++) begin
      cnt_q[t] <= cnt_d[t];
    end
  end

  // holding register per pair
  always_ff @(posedge i_core_clk) begin
    for (int p = 0; p < NUM_PAIR; p++) begin
      if (rd_low[p]) begin
        hold_q[p] <= cnt_q[2*p+1];
      end else if (wr_hold[p]) begin
        hold_q[p] <= wdat;
      end
    end
  end

  // flags: a new event wins over a clearing write
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      flag_q <= '0;
      ena_q  <= '0;
    end else begin
      for (int t = 0; t < NUM_TMR; t++) begin
        flag_q[t] <= ev[t] | (wr_flag ? wdat[FLAG_POS[t]] : flag_q[t]);
        if (wr_ena) begin
          ena_q[t] <= wdat[FLAG_POS[t]];
        end
      end
    end
  end

  // outputs; only pair a feeds the converter and the time base
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pair_a_irq    <= 1'b0;
      o_pair_b_irq    <= 1'b0;
      o_adc_trigger   <= 1'b0;
      o_timebase_low  <= '0;
      o_timebase_high <= '0;
    end else begin
      o_pair_a_irq    <= |(flag_q[1:0] & ena_q[1:0]);
      o_pair_b_irq    <= |(flag_q[3:2] & ena_q[3:2]);
      o_adc_trigger   <= match[1];
      o_timebase_low  <= cnt_q[0];
      o_timebase_high <= cnt_q[1];
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  sequence seq_div8_tick;
    tick[2] && con_q[2][BIT_PRE_H:BIT_PRE_L] == 2'b01 && !wr_con[2];
  endsequence

  sequence seq_quiet7;
    (!tick[2]) [*7];
  endsequence

  // counts power up unknown, so only an enabled counter is watched
  AST_SLEEP_FROZEN:
    assert property ((i_sleep && con_q[0][BIT_ON] && wr_cnt == '0)
                     |=> cnt_q[0] == $past(cnt_q[0]))
    else $error("counter moved during sleep");

  AST_WIDE_MATCH_FLAG:
    assert property ((wide[0] && tick[0] && cnt_q[0] == per_q[0] &&
                      cnt_q[1] == per_q[1]) |=> flag_q[1] && !flag_q[0])
    else $error("wide match did not set upper flag");

  AST_GATE_FALL_FLAG:
    assert property ((wide[1] && gate_fall[2]) |=> flag_q[3])
    else $error("gate falling edge lost");

  AST_FLAG_STICKY:
    assert property ((flag_q[1] && !wr_flag) |=> flag_q[1])
    else $error("flag cleared without software");

  AST_IRQ_GATED:
    assert property (o_pair_a_irq == $past(|(flag_q[1:0] & ena_q[1:0])))
    else $error("interrupt not gated by enable");

  AST_NO_PAIR_B_TRIGGER:
    assert property ((match[3] && !match[1]) |=> !o_adc_trigger)
    else $error("pair b produced converter trigger");

  AST_WIDE_CARRY:
    assert property ((wide[0] && tick[0] && cnt_q[0] == CNT_WRAP &&
                      cnt_q[1] != per_q[1] && wr_cnt == '0)
                     |=> cnt_q[0] == '0 && cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
    else $error("wide carry wrong");

  AST_HOLD_LATCH:
    assert property (rd_low[0] |=> hold_q[0] == $past(cnt_q[1]))
    else $error("hold not latched on low read");

  AST_HOLD_TRANSFER:
    assert property ((wide[0] && wr_cnt[0] && !wr_cnt[1]) |=> cnt_q[1] == $past(hold_q[0]))
    else $error("hold not transferred");

  AST_NARROW_HOLD_IDLE:
    assert property ((!wide[1] && wr_cnt[2] && !wr_cnt[3] && !tick[3])
                     |=> cnt_q[3] == $past(cnt_q[3]))
    else $error("hold disturbed narrow counter");

  AST_PRESCALE_GAP:
    assert property (seq_div8_tick |=> seq_quiet7)
    else $error("prescale 1:8 ticked early");

  AST_NARROW_MATCH:
    assert property ((!wide[1] && tick[3] && cnt_q[3] == per_q[3] && !wr_cnt[3])
                     |=> flag_q[3] && cnt_q[3] == '0)
    else $error("narrow match not flagged");

endmodule : paired_timer_32bit

// ### tb/timer_pin_model.sv
module timer_pin_model (
  input  wire logic       i_clk,
  output logic      [3:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins idle low, nothing drives them outside a pulse or gate window
  initial o_pin = 4'h0;

  task automatic pulses(input int ch, input int n);
    for (int k = 0; k < n; k++) begin
      o_pin[ch] <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_pin[ch] <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask : pulses

  task automatic level(input int ch, input logic v);
    o_pin[ch] <= v;
    @(posedge i_clk);
  endtask : level
endmodule : timer_pin_model

// ### tb/test_paired_timer_32bit.sv
module test_paired_timer_32bit;
  timeunit 1ns;
  timeprecision 1ps;
  import paired_timer_pkg::*;

  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep    = 1'b1;
  logic        idle     = 1'b0;
  logic [3:0]  pin;
  logic        irq_a;
  logic        irq_b;
  logic        adc;
  logic [15:0] tb_low;
  logic [15:0] tb_high;
  logic [31:0] rd;
  logic        err;
  int          fail_count = 0;
  int          n_compared = 0;
  int          adc_n      = 0;
  int unsigned mdl [int];
  logic [15:0] wmask [int];

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (adc === 1'b1) adc_n++;

  paired_timer_32bit u_paired_timer_32bit (
    .i_core_clk(core_clk), .i_reset(reset), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sleep(sleep), .i_idle(idle),
    .i_timer_pin(pin), .o_pair_a_irq(irq_a), .o_pair_b_irq(irq_b),
    .o_adc_trigger(adc), .o_timebase_low(tb_low), .o_timebase_high(tb_high)
  );

  timer_pin_model u_timer_pin_model (.i_clk(core_clk), .o_pin(pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng

  // one transfer; the extra edge at the end keeps back-to-back calls apart
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (wr && mdl.exists(idx)) mdl[idx] = wd & wmask[idx];
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [15:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk(rd, exp);
  endtask : rd_chk

  // outputs are registered, so look at them half a cycle after the edge
  task automatic pin_chk(input logic got_sel, input logic exp);
    @(negedge core_clk);
    chk({31'h0, got_sel ? irq_b : irq_a}, {31'h0, exp});
    @(posedge core_clk);
  endtask : pin_chk

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    void'($urandom(32'hc4ac));
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    // counts power up unknown; upper first so no upper count is ever unknown
    for (int i = NUM_TMR - 1; i >= 0; i--) begin
      wr(CNT_IDX[i], 16'h0000);
    end
    for (int i = 0; i < NUM_TMR; i++) begin
      mdl[PER_IDX[i]]   = 32'h0000_ffff;
      mdl[CON_IDX[i]]   = 32'h0000_0000;
      wmask[PER_IDX[i]] = 16'hffff;
      wmask[CON_IDX[i]] = (i % 2 == 0) ? 16'ha07a : 16'ha072;
      rd_chk(PER_IDX[i], mdl[PER_IDX[i]]);
      rd_chk(CON_IDX[i], mdl[CON_IDX[i]]);
      wr(PER_IDX[i], 16'($urandom));
      wr(CON_IDX[i], 16'hffff);
      rd_chk(PER_IDX[i], mdl[PER_IDX[i]]);
      rd_chk(CON_IDX[i], mdl[CON_IDX[i]]);
      wr(CON_IDX[i], 16'h0000);
    end
    apb(1'b0, 10'h130, 16'h0000);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // pair a wide: 0x0000_fffe up to period 0x0001_0004
    wr(PER_IDX[0], 16'h0004);
    wr(PER_IDX[1], 16'h0001);
    wr(CON_IDX[0], 16'h0008);
    wr(HOLD_IDX[0], 16'h0000);
    wr(CNT_IDX[0], 16'hfffe);
    wr(CON_IDX[1], 16'h0030);
    wr(CON_IDX[0], 16'h8008);
    wr(HOLD_IDX[0], 16'h7777);
    rd_chk(CNT_IDX[0], 32'h0000_fffe);
    rd_chk(HOLD_IDX[0], 32'h0000_0000);
    sleep <= 1'b0;
    repeat (4) @(posedge core_clk);
    sleep <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, CNT_IDX[0], 16'h0000);
    chk_rng(rd, 0, 3);
    rd_chk(HOLD_IDX[0], 32'h0000_0001);
    rd_chk(FLAG_IDX, 32'h0000_0000);
    sleep <= 1'b0;
    repeat (12) @(posedge core_clk);
    rd_chk(FLAG_IDX, 32'h0000_0080);
    chk(adc_n, 1);
    pin_chk(1'b0, 1'b0);
    wr(ENA_IDX, 16'h0080);
    pin_chk(1'b0, 1'b1);
    repeat (20) @(posedge core_clk);
    rd_chk(FLAG_IDX, 32'h0000_0080);
    wr(CON_IDX[0], 16'h0000);
    wr(FLAG_IDX, 16'h0000);
    pin_chk(1'b0, 1'b0);
    wr(CNT_IDX[1], 16'h1234);
    wr(CNT_IDX[0], 16'h5678);
    @(posedge core_clk);
    chk({tb_high, tb_low}, 32'h1234_5678);
    // pair b narrow: upper timer flags its own match, no converter trigger
    sleep <= 1'b1;
    wr(ENA_IDX, 16'h0200);
    wr(CNT_IDX[3], 16'h0000);
    wr(HOLD_IDX[1], 16'h5555);
    wr(CNT_IDX[2], 16'h0000);
    rd_chk(CNT_IDX[3], 32'h0000_0000);
    wr(PER_IDX[3], 16'h0003);
    wr(PER_IDX[2], 16'hffff);
    wr(CON_IDX[3], 16'h8000);
    adc_n = 0;
    sleep <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd_chk(FLAG_IDX, 32'h0000_0200);
    pin_chk(1'b1, 1'b1);
    chk(adc_n, 0);
    sleep <= 1'b1;
    wr(CON_IDX[3], 16'h0000);
    wr(FLAG_IDX, 16'h0000);
    // every prescale setting over a 512-cycle window
    for (int p = 0; p < 4; p++) begin
      wr(CON_IDX[2], 16'h0000);
      wr(CNT_IDX[2], 16'h0000);
      wr(CON_IDX[2], 16'h8000 | 16'(p << 4));
      sleep <= 1'b0;
      repeat (512) @(posedge core_clk);
      sleep <= 1'b1;
      @(posedge core_clk);
      apb(1'b0, CNT_IDX[2], 16'h0000);
      chk_rng(rd, (512 >> (p == 3 ? 8 : 3 * p)) - 1, (512 >> (p == 3 ? 8 : 3 * p)) + 2);
    end
    // halt_in_idle stops timer 2 while the core idles
    wr(CON_IDX[2], 16'h0000);
    wr(CNT_IDX[2], 16'h0000);
    wr(CON_IDX[2], 16'ha000);
    idle  <= 1'b1;
    sleep <= 1'b0;
    repeat (16) @(posedge core_clk);
    rd_chk(CNT_IDX[2], 32'h0000_0000);
    idle  <= 1'b0;
    sleep <= 1'b1;
    // pair b wide on the pin: upper pin ignored, then gate fall
    wr(CON_IDX[2], 16'h000a);
    wr(HOLD_IDX[1], 16'h0000);
    wr(CNT_IDX[2], 16'h0000);
    wr(CON_IDX[2], 16'h800a);
    sleep <= 1'b0;
    u_timer_pin_model.pulses(3, 3);
    u_timer_pin_model.pulses(2, 5);
    repeat (4) @(posedge core_clk);
    rd_chk(CNT_IDX[2], 32'h0000_0005);
    rd_chk(HOLD_IDX[1], 32'h0000_0000);
    wr(CON_IDX[2], 16'h8048);
    wr(FLAG_IDX, 16'h0000);
    u_timer_pin_model.level(2, 1'b1);
    repeat (10) @(posedge core_clk);
    u_timer_pin_model.level(2, 1'b0);
    repeat (8) @(posedge core_clk);
    rd_chk(FLAG_IDX, 32'h0000_0200);
    pin_chk(1'b1, 1'b1);
    end_sim();
  end
endmodule : test_paired_timer_32bit
